// ### rtl/abe_pkg.sv
// abe_pkg: register map, field positions and carrier types for the
// analog block enable register bank.
// assumes a plain strobe register port on a single 25 MHz clock.
package abe_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets (word index on the plain port)
  localparam logic [3:0] ABE_OFFSET     = 4'h0;  // analog_block_enable
  localparam logic [3:0] MEAS_OFFSET    = 4'h1;  // measurement status/done
  localparam logic [3:0] OVTHR_OFFSET   = 4'h2;  // overvolt_threshold
  localparam logic [3:0] UVTHR_OFFSET   = 4'h3;  // undervolt_threshold

  // field positions of analog_block_enable
  localparam int unsigned OVERVOLT_DAC_EN_BIT       = 7;
  localparam int unsigned UNDERVOLT_DAC_EN_BIT      = 6;
  localparam int unsigned EFFICIENCY_MEAS_START_BIT = 5;
  localparam int unsigned SLOPE_COMP_BYPASS_BIT     = 4;
  localparam int unsigned CURRENT_MEAS_EN_BIT       = 3;
  localparam int unsigned TEMP_SENSOR_EN_BIT        = 2;
  localparam int unsigned EFFICIENCY_CIRCUIT_EN_BIT = 1;
  localparam int unsigned SIGNAL_CHAIN_EN_BIT       = 0;

  // values after reset
  localparam logic [7:0] ABE_RESET   = 8'h00;
  localparam logic [7:0] THR_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // enables toward the analog blocks
  typedef struct packed {
    logic       overvolt_dac_en;
    logic       undervolt_dac_en;
    logic       efficiency_meas_start;
    logic       slope_comp_active;
    logic       current_meas_en;
    logic       temp_sensor_en;
    logic       efficiency_circuit_en;
    logic       signal_chain_en;
    logic [7:0] overvolt_threshold;
    logic [7:0] undervolt_threshold;
  } analog_ctl_t;

endpackage

// ### rtl/abe_word_reg.sv
// abe_word_reg: one byte-wide writable register with registered output.
// assumes synchronous active-low reset on the shared system clock.
`timescale 1ns/1ps
`default_nettype none
module abe_word_reg #(
  parameter int unsigned       WIDTH = 8,
  parameter logic [WIDTH-1:0]  RESET = '0
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             we_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);

  // a register needs at least one bit
  if (WIDTH < 1) begin : g_bad_width
    $error("abe_word_reg: width must be at least one");
  end

  // holds the last written value, clears on reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      q_out <= RESET;
    end else if (we_in) begin
      q_out <= d_in;
    end
  end

endmodule
`default_nettype wire

// ### rtl/analog_block_enable.sv
// analog_block_enable: software enable register for the analog blocks of
// a power controller, plus the two threshold registers whose contents are
// masked at ctl_out (read back unmasked) while their detector is switched off.
// assumes one 25 MHz clock, synchronous active-low reset, and a plain
// register port whose read data stand one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bit 7 enables overvoltage DAC
// - bit 5 starts efficiency measurement
// - bit 4 set bypasses slope compensation
// - bit 3 enables peak current measurement
// - bit 2 enables temperature sensor, overtemperature
// - bit 1 enables efficiency measurement circuitry
// - bit 0 enables voltage signal chain
// - overvoltage off ignores its threshold
// - bit 6 enables undervoltage, else threshold ignored
module analog_block_enable #(
  parameter int unsigned MEAS_CYCLES = 16
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  input  wire abe_pkg::reg_req_t     req_in,
  input  wire logic                  meas_done_in,
  output var  logic [7:0]            rdata_out,
  output var  abe_pkg::analog_ctl_t  ctl_out
);
  import abe_pkg::*;

  // refuse a zero count and counts that the 16-bit run counter cannot hold
  if (MEAS_CYCLES < 1 || MEAS_CYCLES > 65535) begin : g_bad_meas_cycles
    $error("MEAS_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_RUN  = 2'b01
  } meas_state_t;

  typedef struct packed {
    logic [7:0]  abe;
    meas_state_t meas;
    logic [15:0] cnt;
    logic        done_sync1;
    logic        done_sync2;
    logic        meas_done_flag;
    logic [7:0]  rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic [7:0] ov_thr;
  logic [7:0] uv_thr;
  logic       abe_wr;

  function automatic logic hit(input reg_req_t r, input logic [3:0] off);
    hit = (r.addr == off);
  endfunction

  // write strobe aimed at the enable register
  assign abe_wr = req_in.wr && hit(req_in, ABE_OFFSET);

  // threshold registers
  abe_word_reg #(.WIDTH(8), .RESET(THR_RESET)) u_ov_thr (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .we_in      (req_in.wr && hit(req_in, OVTHR_OFFSET)),
    .d_in       (req_in.wdata),
    .q_out      (ov_thr)
  );
  abe_word_reg #(.WIDTH(8), .RESET(THR_RESET)) u_uv_thr (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .we_in      (req_in.wr && hit(req_in, UVTHR_OFFSET)),
    .d_in       (req_in.wdata),
    .q_out      (uv_thr)
  );

  // next-state: register writes, measurement sequencing, read mux
  always_comb begin
    st_nxt = st_r;
    st_nxt.done_sync1 = meas_done_in;
    st_nxt.done_sync2 = st_r.done_sync1;
    if (abe_wr) begin
      st_nxt.abe = req_in.wdata;
    end
    if (req_in.wr && hit(req_in, MEAS_OFFSET) && req_in.wdata[0]) begin
      st_nxt.meas_done_flag = 1'b0;
    end
    case (st_r.meas)
      MEAS_IDLE: begin
        // a written one starts a measurement
        if (st_nxt.abe[EFFICIENCY_MEAS_START_BIT]) begin
          st_nxt.meas = MEAS_RUN;
          st_nxt.cnt  = 16'(MEAS_CYCLES);
        end
      end
      MEAS_RUN: begin
        // start bit reads one for the whole run, a written zero cannot hide it
        st_nxt.abe[EFFICIENCY_MEAS_START_BIT] = 1'b1;
        if (st_r.done_sync2 || st_r.cnt == 16'h0001) begin
          st_nxt.meas_done_flag = 1'b1;  // set wins over clear
          if (abe_wr && req_in.wdata[EFFICIENCY_MEAS_START_BIT]) begin
            // a fresh start in the closing cycle is not lost
            st_nxt.cnt = 16'(MEAS_CYCLES);
          end else begin
            st_nxt.meas = MEAS_IDLE;
            st_nxt.abe[EFFICIENCY_MEAS_START_BIT] = 1'b0;
            st_nxt.cnt = 16'h0000;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      default: begin
        st_nxt.meas = MEAS_IDLE;
      end
    endcase
    st_nxt.rdata = UNMAPPED_RD;
    if (req_in.rd) begin
      if (hit(req_in, ABE_OFFSET)) begin
        st_nxt.rdata = st_r.abe;
      end else if (hit(req_in, MEAS_OFFSET)) begin
        st_nxt.rdata = {6'h00, st_r.meas == MEAS_RUN, st_r.meas_done_flag};
      end else if (hit(req_in, OVTHR_OFFSET)) begin
        st_nxt.rdata = ov_thr;
      end else if (hit(req_in, UVTHR_OFFSET)) begin
        st_nxt.rdata = uv_thr;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_r <= '{abe: ABE_RESET, meas: MEAS_IDLE, cnt: 16'h0000,
                done_sync1: 1'b0, done_sync2: 1'b0, meas_done_flag: 1'b0,
                rdata: UNMAPPED_RD};
    end else begin
      st_r <= st_nxt;
    end
  end

  // enables straight from the register, thresholds masked when off
  always_comb begin
    rdata_out = st_r.rdata;
    ctl_out.overvolt_dac_en       = st_r.abe[OVERVOLT_DAC_EN_BIT];
    ctl_out.undervolt_dac_en      = st_r.abe[UNDERVOLT_DAC_EN_BIT];
    ctl_out.efficiency_meas_start = st_r.abe[EFFICIENCY_MEAS_START_BIT];
    ctl_out.slope_comp_active     = !st_r.abe[SLOPE_COMP_BYPASS_BIT];
    ctl_out.current_meas_en       = st_r.abe[CURRENT_MEAS_EN_BIT];
    ctl_out.temp_sensor_en        = st_r.abe[TEMP_SENSOR_EN_BIT];
    ctl_out.efficiency_circuit_en = st_r.abe[EFFICIENCY_CIRCUIT_EN_BIT];
    ctl_out.signal_chain_en       = st_r.abe[SIGNAL_CHAIN_EN_BIT];
    ctl_out.overvolt_threshold    = st_r.abe[OVERVOLT_DAC_EN_BIT] ? ov_thr : 8'h00;
    ctl_out.undervolt_threshold   = st_r.abe[UNDERVOLT_DAC_EN_BIT] ? uv_thr : 8'h00;
  end

endmodule
`default_nettype wire

// ### test/abe_checker_asserts.sv
// abe_checker: port assertions for the analog enable register bank.
// assumes abe_pkg, one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module abe_checker #(
  parameter int unsigned MEAS_CYCLES = 16
) (
  input wire logic                 clk_sys_in,
  input wire logic                 rst_n_in,
  input wire abe_pkg::reg_req_t    req_in,
  input wire logic                 meas_done_in,
  input wire logic [7:0]           rdata_out,
  input wire abe_pkg::analog_ctl_t ctl_out
);
  import abe_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // write strobe aimed at the enable register
  wire w0 = req_in.wr && (req_in.addr == ABE_OFFSET);
  // register contents as the enables show them, slope bit restored
  wire [7:0] reg_view = {ctl_out.overvolt_dac_en, ctl_out.undervolt_dac_en,
                         ctl_out.efficiency_meas_start, !ctl_out.slope_comp_active,
                         ctl_out.current_meas_en, ctl_out.temp_sensor_en,
                         ctl_out.efficiency_circuit_en, ctl_out.signal_chain_en};
  // read data stand one cycle after the strobe, zero otherwise
  rd_back_a: assert property (req_in.rd && req_in.addr == ABE_OFFSET
    |=> rdata_out == $past(reg_view)) else $error("enable readback");
  rd_idle_a: assert property (!req_in.rd |=> rdata_out == UNMAPPED_RD)
    else $error("read data outside read cycle");
  // each enable follows the written bit, meas start only a written one, slope active the inverse
  ov_dac_a: assert property (w0 |=> ctl_out.overvolt_dac_en == $past(req_in.wdata[7]))
    else $error("ov dac enable");
  uv_dac_a: assert property (w0 |=> ctl_out.undervolt_dac_en == $past(req_in.wdata[6]))
    else $error("uv dac enable");
  meas_go_a: assert property (w0 && req_in.wdata[5] |=> ctl_out.efficiency_meas_start)
    else $error("meas start");
  bypass_a: assert property (w0 |=> ctl_out.slope_comp_active != $past(req_in.wdata[4]))
    else $error("slope bypass");
  cur_meas_a: assert property (w0 |=> ctl_out.current_meas_en == $past(req_in.wdata[3]))
    else $error("current meas");
  temp_en_a: assert property (w0 |=> ctl_out.temp_sensor_en == $past(req_in.wdata[2]))
    else $error("temp sensor");
  eff_en_a: assert property (w0 |=> ctl_out.efficiency_circuit_en == $past(req_in.wdata[1]))
    else $error("eff circuit");
  chain_en_a: assert property (w0 |=> ctl_out.signal_chain_en == $past(req_in.wdata[0]))
    else $error("signal chain");
  // thresholds ignored while their detector is off
  ov_mask_a: assert property (!ctl_out.overvolt_dac_en |-> ctl_out.overvolt_threshold == 8'h00)
    else $error("ov threshold not masked");
  uv_mask_a: assert property (!ctl_out.undervolt_dac_en |-> ctl_out.undervolt_threshold == 8'h00)
    else $error("uv threshold not masked");
  // main scenarios
  cover property (w0 && req_in.wdata[5]);
  cover property (req_in.rd);
  cover property ($fell(ctl_out.efficiency_meas_start));
endmodule
bind analog_block_enable abe_checker #(.MEAS_CYCLES(MEAS_CYCLES)) chk (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .req_in(req_in), .meas_done_in(meas_done_in), .rdata_out(rdata_out),
  .ctl_out(ctl_out));
`default_nettype wire

// ### test/tb_analog_block_enable.sv
// tb_analog_block_enable: directed scenarios for the enable register bank.
// assumes abe_pkg and the design compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_analog_block_enable;
  import abe_pkg::*;
  localparam int MEAS_LEN = 8;
  logic        clk_sys_in = 1'b0;
  logic        meas_done = 1'b0;
  logic        rst_n_in = 1'b0;
  reg_req_t    req = '0;
  logic [7:0]  rdata;
  analog_ctl_t ctl;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // clock and hang guard
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  analog_block_enable #(.MEAS_CYCLES(MEAS_LEN)) DUT (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .req_in(req), .meas_done_in(meas_done), .rdata_out(rdata),
    .ctl_out(ctl));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // one strobe cycle, then idle; results settle just after the taking edge
  task automatic bus(logic w, logic r, logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys_in);
    req <= '{a, d, w, r};
    @(posedge clk_sys_in);
    req <= '0;
    #1;
  endtask
  task automatic t_reset;
    bus(0, 1, ABE_OFFSET, 8'h00);
    chk("reset value", ABE_RESET, rdata);
    chk("reset enables", 8'h10, ctl[23:16]);
    chk("reset thresholds", 8'h00, ctl[15:8] | ctl[7:0]);
  endtask
  // every enable bit alone, bit 5 left to the measurement case
  task automatic t_bits;
    for (int i = 0; i < 8; i++) begin
      if (i != 5) begin
        bus(1, 0, ABE_OFFSET, 8'h01 << i);
        chk("enables", (8'h01 << i) ^ 8'h10, ctl[23:16]);
        bus(0, 1, ABE_OFFSET, 8'h00);
        chk("readback", 8'h01 << i, rdata);
        @(posedge clk_sys_in);
        #1;
        chk("read data drops", 8'h00, rdata);
      end
    end
  endtask
  task automatic t_thr;
    bus(1, 0, OVTHR_OFFSET, 8'ha5);
    bus(1, 0, UVTHR_OFFSET, 8'h3c);
    bus(1, 0, ABE_OFFSET, 8'h80);
    chk("ov threshold", 8'ha5, ctl[15:8]);
    chk("uv masked", 8'h00, ctl[7:0]);
    bus(1, 0, ABE_OFFSET, 8'h40);
    chk("uv threshold", 8'h3c, ctl[7:0]);
    chk("ov masked", 8'h00, ctl[15:8]);
    bus(1, 0, 4'hf, 8'hff);
    bus(0, 1, 4'hf, 8'h00);
    chk("unmapped read", UNMAPPED_RD, rdata);
    bus(0, 1, ABE_OFFSET, 8'h00);
    chk("after unmapped write", 8'h40, rdata);
  endtask
  // start a measurement, try to zero it, and wait for the counter to end it
  task automatic t_meas;
    int n;
    n = 0;
    bus(1, 0, ABE_OFFSET, 8'h22);
    chk("meas started", 8'h32, ctl[23:16]);
    bus(1, 0, ABE_OFFSET, 8'h02);
    chk("meas held running", 8'h32, ctl[23:16]);
    while (ctl.efficiency_meas_start === 1'b1 && n < 40) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    // two of the run's cycles went to the zero write
    chk("meas length", 8'(MEAS_LEN - 2), 8'(n));
    bus(0, 1, ABE_OFFSET, 8'h00);
    chk("meas bit clear", 8'h02, rdata);
    bus(0, 1, MEAS_OFFSET, 8'h00);
    chk("done flag set", 8'h01, rdata);
    bus(1, 0, MEAS_OFFSET, 8'h01);
    bus(0, 1, MEAS_OFFSET, 8'h00);
    chk("done flag cleared", 8'h00, rdata);
  endtask
  // an external end-of-measurement cuts the run short
  task automatic t_done;
    int n;
    bus(1, 0, ABE_OFFSET, 8'h20);
    @(posedge clk_sys_in);
    meas_done <= 1'b1;
    n = 1;
    #1;
    while (ctl.efficiency_meas_start === 1'b1 && n < 40) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    // two synchroniser edges plus the state edge after the raising edge
    chk("early end", 8'h04, 8'(n));
    @(posedge clk_sys_in);
    meas_done <= 1'b0;
    bus(0, 1, MEAS_OFFSET, 8'h00);
    chk("done after early end", 8'h01, rdata);
  endtask
  // a reset in mid-run clears every register again
  task automatic t_rst2;
    bus(1, 0, OVTHR_OFFSET, 8'h5a);
    bus(1, 0, ABE_OFFSET, 8'hff);
    chk("all enables on", 8'hef, ctl[23:16]);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    chk("reset enables again", 8'h10, ctl[23:16]);
    bus(0, 1, ABE_OFFSET, 8'h00);
    chk("reset value again", ABE_RESET, rdata);
    bus(0, 1, MEAS_OFFSET, 8'h00);
    chk("reset status", 8'h00, rdata);
    bus(1, 0, ABE_OFFSET, 8'h80);
    chk("reset threshold", THR_RESET, ctl[15:8]);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_bits();
    t_thr();
    t_meas();
    t_done();
    t_rst2();
    final_report();
  end
endmodule
`default_nettype wire
